// ===== hw/prt_timer.sv
// 10-bit periodic timer with compare, timer, PWM, single-pulse and capture modes.
// Assumes an AXI4-Lite master on aclk and asynchronous pins, synchronised here.
//
// Operation
// - mode_select 00 is compare mode; counter clears by overflow, A or P match.
// - clear_source_select low: clear on P match or overflow; both flags raised.
// - clear_source_select high: clear on A match; match_p_flag never set.
// - compare_a_value zero: run to 3FF, overflow, no match_a_flag.
// - Compare mode pin changes on A match: low, high, toggle, or none.
// - Rising counter_run sets compare output to output_initial_level.
// - mode_select 11 counts like compare mode but leaves the pin undriven.
// - PWM clears on P match; clear_source_select ignored.
// - PWM period equals period_value; zero gives 1024 ticks.
// - compare_a_value at or above period gives 100% duty.
// - PWM raises match_a_flag on A match, match_p_flag on P match.
// - PWM pin forced by 00/01; initial level sets polarity; invert flips pin.
// - Single pulse starts on counter_run rise, by software or trigger rising edge.
// - Single pulse A match clears counter_run, ends pulse, raises flag.
// - Software clearing counter_run early also ends the pulse.
// - Single pulse counter zeroes only on counter_run rise; period ignored.
// - Capture mode: selected pin, rising, falling or both edges.
// - Capture copies count into compare_a_value, raises flag, counter runs on.
// - Capture P match resets counter with flag; pin_function 11 disables capture.
// - Capture flag follows latch; latch follows pin edge within three aclk cycles.
// - counter_run rise zeroes counter; fall stops it holding its value.
`timescale 1ns/100ps
`default_nettype none

module prt_timer (
	// Clock and reset.
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// AXI4-Lite write address and data.
	input  wire logic [prt_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [prt_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [prt_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [prt_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Pins.
	input  wire logic                        capture_pin,
	input  wire logic                        external_trigger_pin,
	output logic                             timer_out,
	output logic                             timer_out_oe
);
	import prt_pkg::*;

	// Merges a write word into a register under the byte strobes.
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] strb);
		logic [DATA_W-1:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Decides whether an edge is active for the capture setting.
	function automatic logic edge_hit(input logic [1:0] fn, input logic rise, input logic fall);
		logic hit;
		hit = 1'b0;
		case (fn)
			PIN_FN_00: hit = rise;
			PIN_FN_01: hit = fall;
			PIN_FN_10: hit = rise | fall;
			default:   hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Pin synchronisers; the first stages feed only the second stages.
	logic cap_s1_reg, cap_s2_reg, cap_s3_reg;
	logic trg_s1_reg, trg_s2_reg, trg_s3_reg;

	// Bus state.
	logic                 aw_hold_reg, aw_hold_next;
	logic [ADDR_W-1:0]    aw_addr_reg, aw_addr_next;
	logic                 w_hold_reg, w_hold_next;
	logic [DATA_W-1:0]    w_data_reg, w_data_next;
	logic [3:0]           w_strb_reg, w_strb_next;
	logic                 bvalid_reg, bvalid_next;
	logic [1:0]           bresp_reg, bresp_next;
	logic                 rvalid_reg, rvalid_next;
	logic [1:0]           rresp_reg, rresp_next;
	logic [DATA_W-1:0]    rdata_reg, rdata_next;

	// Timer state.
	prt_cfg_s             cfg_reg, cfg_next;
	logic                 run_reg, run_next;
	logic                 run_d_reg, run_d_next;
	logic [CNT_W-1:0]     cnt_reg, cnt_next;
	logic [CNT_W-1:0]     compa_reg, compa_next;
	logic [CNT_W-1:0]     period_reg, period_next;
	logic                 flag_a_reg, flag_a_next;
	logic                 flag_p_reg, flag_p_next;
	logic                 cap_pend_reg, cap_pend_next;
	logic                 cmp_out_reg, cmp_out_next;
	logic                 out_reg, out_next;
	logic                 oe_reg, oe_next;
	logic [DIV_W-1:0]     presc_reg, presc_next;
	logic [DIV_W-1:0]     div_reg, div_next;

	// Combinational helpers.
	logic                 wr_fire, tick, run_rise;
	logic                 single_pulse, pwm_active, pwm_level;
	logic                 a_match, p_match, a_valid;
	logic                 cap_rise, cap_fall, trg_rise, trg_fall, cap_edge;
	logic [CNT_W-1:0]     cnt_inc;
	logic [DATA_W-1:0]    wr_word;

	assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign timer_out     = out_reg;
	assign timer_out_oe  = oe_reg;

	always_comb begin
		wr_fire  = aw_hold_reg & w_hold_reg & ~bvalid_reg;
		tick     = (div_reg == presc_reg);
		run_rise = run_reg & ~run_d_reg;
		cnt_inc  = cnt_reg + 10'h001;
		single_pulse = (cfg_reg.mode_select == MODE_PWM) &&
			(cfg_reg.pin_function_select == PIN_FN_11);
		cap_rise = cap_s2_reg & ~cap_s3_reg;
		cap_fall = ~cap_s2_reg & cap_s3_reg;
		trg_rise = trg_s2_reg & ~trg_s3_reg;
		trg_fall = ~trg_s2_reg & trg_s3_reg;
		cap_edge = cfg_reg.capture_source_select ?
			edge_hit(cfg_reg.pin_function_select, trg_rise, trg_fall) :
			edge_hit(cfg_reg.pin_function_select, cap_rise, cap_fall);
		// A zero compare value never matches, so the counter runs to 3FF instead.
		a_valid = (compa_reg != CNT_ZERO);
		a_match = run_reg & ~run_rise & tick & a_valid & (cnt_inc == compa_reg);
		// A zero period compares against the wrapped count, which is the overflow.
		p_match = run_reg & ~run_rise & tick & (cnt_inc == period_reg);
		pwm_active = (cnt_reg < compa_reg) ||
			((period_reg != CNT_ZERO) && (compa_reg >= period_reg));
		case (cfg_reg.pin_function_select)
			PIN_FN_00: pwm_level = 1'b0;
			PIN_FN_01: pwm_level = 1'b1;
			PIN_FN_10: pwm_level = pwm_active;
			default:   pwm_level = run_reg;
		endcase
	end

	always_comb begin
		wr_word      = '0;
		aw_hold_next = aw_hold_reg;
		aw_addr_next = aw_addr_reg;
		w_hold_next  = w_hold_reg;
		w_data_next  = w_data_reg;
		w_strb_next  = w_strb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		cfg_next     = cfg_reg;
		run_next     = run_reg;
		run_d_next   = run_reg;
		cnt_next     = cnt_reg;
		compa_next   = compa_reg;
		period_next  = period_reg;
		flag_a_next  = flag_a_reg;
		flag_p_next  = flag_p_reg;
		cap_pend_next = 1'b0;
		cmp_out_next = cmp_out_reg;
		presc_next   = presc_reg;
		div_next     = tick ? '0 : DIV_W'(div_reg + 16'h0001);

		// Write channel.
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (wr_fire) begin
			aw_hold_next = 1'b0;
			w_hold_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = RESP_OKAY;
			if (aw_addr_reg == ADDR_CTRL) begin
				wr_word  = merge({31'h0000_0000, run_reg}, w_data_reg, w_strb_reg);
				run_next = wr_word[CTRL_RUN_BIT];
			end else if (aw_addr_reg == ADDR_CONFIG) begin
				wr_word  = merge({24'h00_0000, cfg_reg}, w_data_reg, w_strb_reg);
				cfg_next = prt_cfg_s'(wr_word[7:0]);
			end else if (aw_addr_reg == ADDR_COMPA) begin
				wr_word    = merge({22'h00_0000, compa_reg}, w_data_reg, w_strb_reg);
				compa_next = wr_word[CNT_W-1:0];
			end else if (aw_addr_reg == ADDR_PERIOD) begin
				wr_word     = merge({22'h00_0000, period_reg}, w_data_reg, w_strb_reg);
				period_next = wr_word[CNT_W-1:0];
			end else if (aw_addr_reg == ADDR_STATUS) begin
				wr_word = merge(32'h0000_0000, w_data_reg, w_strb_reg);
				if (wr_word[STATUS_A_BIT]) begin
					flag_a_next = 1'b0;
				end
				if (wr_word[STATUS_P_BIT]) begin
					flag_p_next = 1'b0;
				end
			end else if (aw_addr_reg == ADDR_PRESC) begin
				wr_word    = merge({16'h0000, presc_reg}, w_data_reg, w_strb_reg);
				presc_next = wr_word[DIV_W-1:0];
			end else if (aw_addr_reg != ADDR_COUNT) begin
				bresp_next = RESP_SLVERR;
			end
		end

		// Read channel.
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next  = RESP_OKAY;
			rdata_next  = '0;
			if (s_axi_araddr == ADDR_CTRL) begin
				rdata_next[CTRL_RUN_BIT] = run_reg;
			end else if (s_axi_araddr == ADDR_CONFIG) begin
				rdata_next[7:0] = cfg_reg;
			end else if (s_axi_araddr == ADDR_COUNT) begin
				rdata_next[CNT_W-1:0] = cnt_reg;
			end else if (s_axi_araddr == ADDR_COMPA) begin
				rdata_next[CNT_W-1:0] = compa_reg;
			end else if (s_axi_araddr == ADDR_PERIOD) begin
				rdata_next[CNT_W-1:0] = period_reg;
			end else if (s_axi_araddr == ADDR_STATUS) begin
				rdata_next[STATUS_A_BIT]   = flag_a_reg;
				rdata_next[STATUS_P_BIT]   = flag_p_reg;
				rdata_next[STATUS_OUT_BIT] = out_reg;
			end else if (s_axi_araddr == ADDR_PRESC) begin
				rdata_next[DIV_W-1:0] = presc_reg;
			end else begin
				rresp_next = RESP_SLVERR;
			end
		end

		// Counter. Hardware events below come after the bus so that a set beats a clear.
		if (run_rise) begin
			cnt_next     = CNT_ZERO;
			cmp_out_next = cfg_reg.output_initial_level;
		end else if (run_reg && tick) begin
			cnt_next = cnt_inc;
		end
		if (single_pulse && !run_reg && trg_rise) begin
			run_next = 1'b1;
		end
		case (cfg_reg.mode_select)
			MODE_COMPARE, MODE_TIMER: begin
				if (cfg_reg.clear_source_select) begin
					if (a_match) begin
						cnt_next = CNT_ZERO;
					end
				end else if (p_match) begin
					cnt_next    = CNT_ZERO;
					flag_p_next = 1'b1;
				end
				if (a_match) begin
					flag_a_next = 1'b1;
					case (cfg_reg.pin_function_select)
						PIN_FN_01: cmp_out_next = 1'b0;
						PIN_FN_10: cmp_out_next = 1'b1;
						PIN_FN_11: cmp_out_next = ~cmp_out_reg;
						default:   cmp_out_next = cmp_out_reg;
					endcase
				end
			end
			MODE_PWM: begin
				if (single_pulse) begin
					// Period is ignored here; an A match stops the run and ends the pulse.
					if (a_match) begin
						run_next    = 1'b0;
						flag_a_next = 1'b1;
					end
				end else begin
					if (p_match) begin
						cnt_next    = CNT_ZERO;
						flag_p_next = 1'b1;
					end
					if (a_match) begin
						flag_a_next = 1'b1;
					end
				end
			end
			default: begin
				if (p_match) begin
					cnt_next    = CNT_ZERO;
					flag_p_next = 1'b1;
				end
				// The count is latched on the edge cycle and the flag one cycle later.
				if (run_reg && cap_edge) begin
					compa_next    = cnt_reg;
					cap_pend_next = 1'b1;
				end
				if (cap_pend_reg) begin
					flag_a_next = 1'b1;
				end
			end
		endcase

		// Pin. Compare mode drives the held level; PWM levels follow the polarity bits.
		case (cfg_reg.mode_select)
			MODE_COMPARE: begin
				out_next = cmp_out_next;
				oe_next  = 1'b1;
			end
			MODE_PWM: begin
				out_next = (pwm_level ~^ cfg_reg.output_initial_level) ^
					cfg_reg.output_invert;
				oe_next  = 1'b1;
			end
			default: begin
				out_next = 1'b0;
				oe_next  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		cap_s1_reg <= capture_pin;
		cap_s2_reg <= cap_s1_reg;
		cap_s3_reg <= cap_s2_reg;
		trg_s1_reg <= external_trigger_pin;
		trg_s2_reg <= trg_s1_reg;
		trg_s3_reg <= trg_s2_reg;
		if (!aresetn) begin
			aw_hold_reg  <= 1'b0;
			aw_addr_reg  <= '0;
			w_hold_reg   <= 1'b0;
			w_data_reg   <= '0;
			w_strb_reg   <= '0;
			bvalid_reg   <= 1'b0;
			bresp_reg    <= RESP_OKAY;
			rvalid_reg   <= 1'b0;
			rresp_reg    <= RESP_OKAY;
			rdata_reg    <= '0;
			cfg_reg      <= CFG_RESET;
			run_reg      <= 1'b0;
			run_d_reg    <= 1'b0;
			cnt_reg      <= CNT_ZERO;
			compa_reg    <= CNT_ZERO;
			period_reg   <= CNT_ZERO;
			flag_a_reg   <= 1'b0;
			flag_p_reg   <= 1'b0;
			cap_pend_reg <= 1'b0;
			cmp_out_reg  <= 1'b0;
			out_reg      <= 1'b0;
			oe_reg       <= 1'b0;
			presc_reg    <= PRESC_RESET;
			div_reg      <= '0;
		end else begin
			aw_hold_reg  <= aw_hold_next;
			aw_addr_reg  <= aw_addr_next;
			w_hold_reg   <= w_hold_next;
			w_data_reg   <= w_data_next;
			w_strb_reg   <= w_strb_next;
			bvalid_reg   <= bvalid_next;
			bresp_reg    <= bresp_next;
			rvalid_reg   <= rvalid_next;
			rresp_reg    <= rresp_next;
			rdata_reg    <= rdata_next;
			cfg_reg      <= cfg_next;
			run_reg      <= run_next;
			run_d_reg    <= run_d_next;
			cnt_reg      <= cnt_next;
			compa_reg    <= compa_next;
			period_reg   <= period_next;
			flag_a_reg   <= flag_a_next;
			flag_p_reg   <= flag_p_next;
			cap_pend_reg <= cap_pend_next;
			cmp_out_reg  <= cmp_out_next;
			out_reg      <= out_next;
			oe_reg       <= oe_next;
			presc_reg    <= presc_next;
			div_reg      <= div_next;
		end
	end

endmodule

`default_nettype wire

// ===== shared/prt_pkg.sv
// Constants and carrier types of the 10-bit periodic timer with its AXI4-Lite register file.
// Assumes a single 20 MHz clock and a synchronous active-low reset in every user.
package prt_pkg;

	// Clock rate, kept for any timing derived later.
	localparam int unsigned CLK_HZ = 20_000_000;

	// Counter and bus widths.
	localparam int CNT_W  = 10;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int DIV_W  = 16;
	localparam logic [CNT_W-1:0] CNT_MAX  = 10'h3FF;
	localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_COUNT  = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_COMPA  = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_PRESC  = 8'h18;

	// Field positions.
	localparam int CTRL_RUN_BIT    = 0;
	localparam int STATUS_A_BIT    = 0;
	localparam int STATUS_P_BIT    = 1;
	localparam int STATUS_OUT_BIT  = 2;
	localparam int CFG_CLR_BIT     = 0;
	localparam int CFG_CAPSRC_BIT  = 1;
	localparam int CFG_INVERT_BIT  = 2;
	localparam int CFG_INIT_BIT    = 3;
	localparam int CFG_PINFN_LSB   = 4;
	localparam int CFG_MODE_LSB    = 6;

	// Reset values.
	localparam logic [DIV_W-1:0] PRESC_RESET = 16'h0000;

	// Operating mode codes of mode_select.
	localparam logic [1:0] MODE_COMPARE = 2'b00;
	localparam logic [1:0] MODE_CAPTURE = 2'b01;
	localparam logic [1:0] MODE_PWM     = 2'b10;
	localparam logic [1:0] MODE_TIMER   = 2'b11;

	// Codes of pin_function_select.
	localparam logic [1:0] PIN_FN_00 = 2'b00;
	localparam logic [1:0] PIN_FN_01 = 2'b01;
	localparam logic [1:0] PIN_FN_10 = 2'b10;
	localparam logic [1:0] PIN_FN_11 = 2'b11;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [1:0] mode_select;
		logic [1:0] pin_function_select;
		logic       output_initial_level;
		logic       output_invert;
		logic       capture_source_select;
		logic       clear_source_select;
	} prt_cfg_s;

	localparam prt_cfg_s CFG_RESET = '0;

endpackage

// ===== tb/periodic_timer_modes_tb_top.sv
// Self-checking bench for the periodic timer through its AXI4-Lite registers.
// Assumes the prescaler stays at reset, so the timer ticks on every aclk.
`timescale 1ns/100ps
`default_nettype none

module periodic_timer_modes_tb_top;
	import prt_pkg::*;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic [3:0]        wstrb = 4'hF;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic              awready, wready, bvalid, arready, rvalid, timer_out, timer_out_oe;
	logic              capture_pin, external_trigger_pin;
	logic [1:0]        bresp, rresp;
	logic [DATA_W-1:0] rdata;
	int                fail_count = 0;
	int                check_count = 0;

	always #25 aclk = ~aclk;

	prt_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .capture_pin(capture_pin), .external_trigger_pin(external_trigger_pin),
		.timer_out(timer_out), .timer_out_oe(timer_out_oe));
	prt_pin_model pins (.aclk(aclk), .capture_pin(capture_pin),
		.external_trigger_pin(external_trigger_pin));

	task automatic complete_run();
		if (fail_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic limit(input int n);
		if (n >= 200) begin
			check("handshake", 0, 1);
			complete_run();
		end
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 200);
		limit(n);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 200);
		limit(n);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_write(a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic [1:0] r;
		axi_read(a, d, r);
	endtask

	task automatic chk_rd(input string name, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		check(name, d & m, exp);
	endtask

	// Stops the timer before reconfiguring, since mode changes while running are undefined.
	task automatic setup(input logic [1:0] m, input logic [1:0] fn, input logic [3:0] bits,
		input int ca, input int per);
		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_CONFIG, {24'h00_0000, m, fn, bits});
		wr(ADDR_COMPA, ca);
		wr(ADDR_PERIOD, per);
		wr(ADDR_STATUS, 32'h0000_0003);
		wr(ADDR_CTRL, 32'h0000_0001);
	endtask

	task automatic count_high(input int cycles, output int highs);
		highs = 0;
		repeat (cycles) begin
			@(posedge aclk);
			if (timer_out === 1'b1) highs++;
		end
	endtask

	task automatic t_basics();
		logic [31:0] d;
		logic [1:0]  r;
		chk_rd("config", ADDR_CONFIG, 32'hFFFF_FFFF, 32'h0000_0000);
		chk_rd("prescaler", ADDR_PRESC, 32'hFFFF_FFFF, 32'h0000_0000);
		axi_write(8'h40, 32'hFFFF_FFFF, r);
		check("bresp", r, RESP_SLVERR);
		axi_read(8'h40, d, r);
		check("rresp", r, RESP_SLVERR);
		check("rdata", d, 32'h0000_0000);
	endtask

	task automatic t_compare();
		int h;
		for (int fn = 0; fn < 4; fn++) begin
			setup(MODE_COMPARE, fn[1:0], {fn == 1, 3'b000}, 5, 10);
			repeat (2) @(posedge aclk);
			check("initial level", timer_out, fn == 1);
			if (fn == 3) begin
				count_high(40, h);
				check("toggle duty", h, 20);
			end else begin
				repeat (20) @(posedge aclk);
				check("match level", timer_out, fn == 2);
			end
		end
		chk_rd("flags", ADDR_STATUS, 32'h0000_0003, 32'h0000_0003);
		check("pin enable", timer_out_oe, 1'b1);
	endtask

	task automatic t_clear_modes();
		logic [31:0] c1;
		logic [31:0] c2;
		setup(MODE_COMPARE, PIN_FN_00, 4'b0001, 8, 3);
		repeat (30) @(posedge aclk);
		chk_rd("flags", ADDR_STATUS, 32'h0000_0003, 32'h0000_0001);
		rd(ADDR_COUNT, c1);
		check("count range", c1 < 8, 1'b1);
		setup(MODE_COMPARE, PIN_FN_00, 4'b0000, 0, 0);
		rd(ADDR_COUNT, c1);
		rd(ADDR_COUNT, c2);
		check("count step", c2 - c1, 3);
		repeat (1100) @(posedge aclk);
		chk_rd("flags", ADDR_STATUS, 32'h0000_0003, 32'h0000_0002);
		setup(MODE_TIMER, PIN_FN_11, 4'b1000, 5, 10);
		repeat (20) @(posedge aclk);
		check("pin enable", timer_out_oe, 1'b0);
		chk_rd("flags", ADDR_STATUS, 32'h0000_0003, 32'h0000_0003);
	endtask

	task automatic t_pwm();
		int         h;
		int         per[6] = '{8, 8, 8, 0, 8, 8};
		int         ca[6] = '{2, 9, 2, 3, 2, 2};
		int         win[6] = '{16, 16, 16, 1024, 16, 16};
		int         exp_h[6] = '{4, 16, 12, 3, 16, 0};
		logic [1:0] fn[6] = '{2'b10, 2'b10, 2'b10, 2'b10, 2'b00, 2'b01};
		logic [3:0] bits[6] = '{4'b1001, 4'b1000, 4'b1100, 4'b1000, 4'b0000, 4'b0000};
		for (int i = 0; i < 6; i++) begin
			setup(MODE_PWM, fn[i], bits[i], ca[i], per[i]);
			repeat (4) @(posedge aclk);
			count_high(win[i], h);
			check("pwm highs", h, exp_h[i]);
		end
		chk_rd("flags", ADDR_STATUS, 32'h0000_0003, 32'h0000_0003);
	endtask

	task automatic t_pulse();
		logic [31:0] c1;
		logic [31:0] c2;
		setup(MODE_PWM, PIN_FN_11, 4'b1000, 6, 3);
		repeat (2) @(posedge aclk);
		check("pulse lead", timer_out, 1'b1);
		repeat (20) @(posedge aclk);
		chk_rd("run bit", ADDR_CTRL, 32'h0000_0001, 32'h0000_0000);
		chk_rd("flag a", ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
		check("pulse trail", timer_out, 1'b0);
		rd(ADDR_COUNT, c1);
		rd(ADDR_COUNT, c2);
		check("count held", c2, c1);
		wr(ADDR_STATUS, 32'h0000_0003);
		pins.drive(1'b1, 1'b1);
		repeat (20) @(posedge aclk);
		chk_rd("trigger flag", ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
		pins.drive(1'b1, 1'b0);
		setup(MODE_PWM, PIN_FN_11, 4'b1000, 500, 3);
		repeat (10) @(posedge aclk);
		wr(ADDR_CTRL, 32'h0000_0000);
		repeat (3) @(posedge aclk);
		check("early trail", timer_out, 1'b0);
		chk_rd("flag a", ADDR_STATUS, 32'h0000_0001, 32'h0000_0000);
	endtask

	task automatic t_capture();
		logic [31:0] ca;
		logic [31:0] c;
		for (int i = 0; i < 8; i++) begin
			setup(MODE_CAPTURE, i[1:0], {2'b00, i[2], 1'b0}, 0, 0);
			pins.drive(i[2], 1'b1);
			repeat (10) @(posedge aclk);
			chk_rd("rise flag", ADDR_STATUS, 1, i[1:0] == 0 || i[1:0] == 2);
			wr(ADDR_STATUS, 32'h0000_0003);
			pins.drive(i[2], 1'b0);
			repeat (10) @(posedge aclk);
			chk_rd("fall flag", ADDR_STATUS, 1, i[1:0] == 1 || i[1:0] == 2);
		end
		setup(MODE_CAPTURE, PIN_FN_00, 4'b0000, 0, 0);
		repeat (20) @(posedge aclk);
		pins.drive(1'b0, 1'b1);
		repeat (10) @(posedge aclk);
		rd(ADDR_COMPA, ca);
		rd(ADDR_COUNT, c);
		check("latched count", ca > 20 && ca < c, 1'b1);
		check("pin enable", timer_out_oe, 1'b0);
		pins.drive(1'b0, 1'b0);
	endtask

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_basics();
		t_compare();
		t_clear_modes();
		t_pwm();
		t_pulse();
		t_capture();
		complete_run();
	end
endmodule

`default_nettype wire

// ===== tb/prt_pin_model.sv
// Far-side pin driver for the periodic timer: capture and trigger inputs.
// Assumes the bench calls drive() from its stimulus process on aclk.
`timescale 1ns/100ps
`default_nettype none

module prt_pin_model (
	// Clock.
	input  wire logic aclk,
	// Pins into the timer.
	output logic      capture_pin,
	output logic      external_trigger_pin
);
	initial begin
		capture_pin = 1'b0;
		external_trigger_pin = 1'b0;
	end

	// Callers hold each level for many timer clocks, never a runt pulse.
	task automatic drive(input logic sel, input logic level);
		@(posedge aclk);
		if (sel) external_trigger_pin <= level;
		else capture_pin <= level;
	endtask
endmodule

`default_nettype wire

// ===== tb/prt_timer_monitor.sv
// Concurrent checks on the AXI4-Lite slave and the pin enable of the timer.
// Bound to prt_timer; sees its ports only, single clock aclk.
`timescale 1ns/100ps
`default_nettype none

module prt_timer_monitor (
	// Clock and reset.
	input wire logic                       aclk,
	input wire logic                       aresetn,
	// Write channels.
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic [1:0]                 s_axi_bresp,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	// Read channels.
	input wire logic [prt_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [prt_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready,
	// Pin.
	input wire logic                       timer_out,
	input wire logic                       timer_out_oe
);
	import prt_pkg::*;
	logic ar_bad_reg;
	logic ar_bad_next;

	// Remembers whether the read under way went beyond the last register.
	always_comb begin
		ar_bad_next = ar_bad_reg;
		if (s_axi_arvalid && s_axi_arready) ar_bad_next = s_axi_araddr > ADDR_PRESC;
	end
	always_ff @(posedge aclk) begin
		ar_bad_reg <= aresetn ? ar_bad_next : 1'b0;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_pair_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_resp_soon;
		##[1:2] s_axi_bvalid;
	endsequence

	a_reset_idle: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !timer_out_oe)
		else $error("outputs not idle after reset");
	a_write_answer: assert property (s_pair_taken |-> s_resp_soon)
		else $error("write response missing");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while busy");
	a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while busy");
	a_unmapped_read: assert property (s_axi_rvalid && ar_bad_reg |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
		else $error("unmapped read answered");
	a_undriven_low: assert property (!timer_out_oe [*2] |-> !timer_out)
		else $error("pin level while undriven");
endmodule

bind prt_timer prt_timer_monitor mon (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.timer_out(timer_out), .timer_out_oe(timer_out_oe)
);

`default_nettype wire
